/* hw/rcad_core.sv */
// execution core: fetch/execute pipeline, 8-bit alu, core registers
// assumes synchronous program and data memories on the same clock,
// and a master clear pin that is asynchronous to that clock
`timescale 1ns/1ps

// Summary of operation
// - single 14-bit instruction word per fetch
// - fetch overlaps execute, one cycle each
// - separate program and data memory ports
// - core registers, pc included, live in file space
// - every byte and bit op works on any file address
// - 8-bit add, subtract, shift, logic
// - arithmetic is two's complement
// - two operands: accumulator plus file or literal
// - single operand: accumulator or file register
// - accumulator is 8 bits, not addressable
// - alu updates carry, nibble carry, zero
// - subtract: carry and nibble carry mean no-borrow
// - cycle rate is clock over four, optional output
// - low master clear resets, pull-up stays on
// - four phases; pc bumps phase one, latch phase four
// - operand read phase two, write phase four
// - pc-changing instruction takes two cycles
// - fetch starts at 0000h, interrupt goes 0004h
module rcad_core
  import rcad_pkg::*;
(
  input  logic        clk,
  input  logic        reset,
  input  logic        master_clear_in,
  input  logic        master_clear_enable,
  input  logic        external_rc_osc_mode,
  input  logic        internal_rc_osc_mode,
  input  logic        clock_out_select,
  input  logic        irq_req,
  input  logic        irq_enable,
  input  logic [13:0] prog_data,
  input  logic [7:0]  data_rdata,
  output logic [12:0] prog_addr,
  output logic [7:0]  data_addr,
  output logic        data_rd,
  output logic        data_wr,
  output logic [7:0]  data_wdata,
  output logic        cycle_rate_clock_out,
  output logic        master_clear_pullup_on
);

  rcad_phase_e  ph_r;
  logic [12:0]  pc_r;
  logic [12:0]  pc_nxt;
  logic [12:0]  pc_inc;
  logic [12:0]  pc_tgt;
  logic [12:0]  prog_addr_r;
  logic [13:0]  instruction_latch_r;
  logic [7:0]   w_r;
  logic [7:0]   status_r;
  logic [7:0]   status_nxt;
  logic [7:0]   status_base;
  logic [7:0]   pointer_r;
  logic [4:0]   pc_high_r;
  logic [12:0]  stack_r [STACK_N];
  logic [2:0]   sp_r;
  logic         in_isr_r;
  logic [7:0]   data_addr_r;
  logic         data_rd_r;
  logic         data_wr_r;
  logic [7:0]   data_wdata_r;
  logic [7:0]   res_r;
  logic         alu_c_r;
  logic         alu_dc_r;
  logic         skip_r;
  logic         clk_out_r;
  logic         pullup_r;
  logic         master_clear_in_s1_r;
  logic         master_clear_in_s2_r;
  logic         core_rst;
  logic         fresh_r;

  // decode fields
  logic [1:0]   cls;
  logic [3:0]   op;
  logic         dbit;
  logic [6:0]   f7;
  logic [2:0]   bsel;
  logic [7:0]   k8;
  logic         is_byte;
  logic         is_bit;
  logic         is_lit;
  logic         is_call;
  logic         is_goto;
  logic         is_ret;
  logic         is_sub;
  logic         arith;
  logic         upd_c;
  logic         upd_dc;
  logic         upd_z;
  logic         to_w;
  logic         to_f;
  logic         rd_f;

  // operand and address
  logic [7:0]   ea;
  logic         core_hit;
  logic         ext;
  logic [7:0]   core_rd;
  logic [7:0]   opnd;
  logic [7:0]   b_op;
  logic [7:0]   arith_y;
  logic [8:0]   sum9;
  logic [4:0]   nib5;
  logic [7:0]   bmask;
  logic         bit_val;
  logic [7:0]   alu_res;
  logic         alu_c;
  logic         alu_dc;
  logic         alu_skip;

  // commit controls
  logic         commit;
  logic         wr_core;
  logic         pcl_wr;
  logic         flow;
  logic         take_irq;
  logic         push;
  logic         pop;
  logic         co_en;

  // master clear pin: two flops before use
  always_ff @(posedge clk) begin
    if (reset) begin
      master_clear_in_s1_r <= 1'b1;
      master_clear_in_s2_r <= 1'b1;
      pullup_r  <= 1'b1;
    end else begin
      master_clear_in_s1_r <= master_clear_in;
      master_clear_in_s2_r <= master_clear_in_s1_r;
      pullup_r  <= master_clear_enable;
    end
  end

  // low level on the pin holds the whole core in reset when master_clear_enable is set
  assign core_rst = reset | (master_clear_enable & ~master_clear_in_s2_r);

  // instruction field split, one 14-bit word per instruction
  assign cls     = instruction_latch_r[13:12];
  assign op      = instruction_latch_r[11:8];
  assign dbit    = instruction_latch_r[7];
  assign f7      = instruction_latch_r[6:0];
  assign bsel    = instruction_latch_r[9:7];
  assign k8      = instruction_latch_r[7:0];
  assign is_byte = (cls == 2'b00);
  assign is_bit  = (cls == 2'b01);
  assign is_lit  = (cls == 2'b11);
  assign is_call = (cls == 2'b10) & ~op[3];
  assign is_goto = (cls == 2'b10) & op[3];
  assign is_ret  = (instruction_latch_r == OP_RETURN)
                 | (instruction_latch_r == OP_RETFIE)
                 | (is_lit & (op[3:2] == 2'b01));

  // flag and destination decode
  assign is_sub = (is_byte & (op == 4'h2)) | (is_lit & (op[3:1] == 3'b110));
  assign arith  = (is_byte & ((op == 4'h2) | (op == 4'h7)))
                | (is_lit & (op[3:2] == 2'b11));
  assign upd_c  = arith | (is_byte & (op[3:1] == 3'b110));
  assign upd_dc = arith;
  assign upd_z  = arith | (is_byte & Z_BYTE_MASK[op])
                | (is_lit & (op[3:2] == 2'b10));
  assign to_w   = (is_byte & ~dbit & (op != 4'h0)) | is_lit;
  assign to_f   = (is_byte & dbit) | (is_bit & ~op[3]);
  assign rd_f   = is_byte | is_bit;

  // direct or indirect file address, same path for every register
  assign ea = (f7 == A_INDIRECT) ? pointer_r : {status_r[ST_RP0], f7};
  assign core_hit = (ea[6:0] == A_INDIRECT) | (ea[6:0] == A_PC_LOW)
                  | (ea[6:0] == A_STATUS) | (ea[6:0] == A_POINTER)
                  | (ea[6:0] == A_PC_HIGH);
  assign ext = ~core_hit;

  // core registers read back like memory; indirect through 00h reads 0
  assign core_rd = (ea[6:0] == A_PC_LOW)  ? pc_r[7:0] :
                   (ea[6:0] == A_STATUS)  ? status_r :
                   (ea[6:0] == A_POINTER) ? pointer_r :
                   (ea[6:0] == A_PC_HIGH) ? {3'h0, pc_high_r} : 8'h00;

  // operands: accumulator against file register or literal
  assign opnd    = ext ? data_rdata : core_rd;
  assign b_op    = is_lit ? k8 : opnd;
  assign arith_y = is_sub ? ~w_r : w_r;
  assign sum9    = {1'b0, b_op} + {1'b0, arith_y} + {8'h00, is_sub};
  assign nib5    = {1'b0, b_op[3:0]} + {1'b0, arith_y[3:0]} + {4'h0, is_sub};
  assign bmask   = 8'(8'h01 << bsel);
  assign bit_val = |(opnd & bmask);

  // alu; carry out of a subtract is set when no borrow occurred
  always_comb begin
    alu_res  = b_op;
    alu_c    = sum9[8];
    alu_dc   = nib5[4];
    alu_skip = 1'b0;
    if (is_bit) begin
      case (op[3:2])
        2'b00:   alu_res = opnd & ~bmask;
        2'b01:   alu_res = opnd | bmask;
        2'b10:   alu_skip = ~bit_val;
        default: alu_skip = bit_val;
      endcase
    end else if (is_lit) begin
      case (op)
        4'h8:    alu_res = w_r | k8;
        4'h9:    alu_res = w_r & k8;
        4'ha:    alu_res = w_r ^ k8;
        4'hc, 4'hd, 4'he, 4'hf: alu_res = sum9[7:0];
        default: alu_res = k8;
      endcase
    end else begin
      case (op)
        4'h0:    alu_res = w_r;
        4'h1:    alu_res = 8'h00;
        4'h2:    alu_res = sum9[7:0];
        4'h3:    alu_res = opnd - 8'h01;
        4'h4:    alu_res = w_r | opnd;
        4'h5:    alu_res = w_r & opnd;
        4'h6:    alu_res = w_r ^ opnd;
        4'h7:    alu_res = sum9[7:0];
        4'h9:    alu_res = ~opnd;
        4'ha:    alu_res = opnd + 8'h01;
        4'hb: begin
          alu_res  = opnd - 8'h01;
          alu_skip = (opnd == 8'h01);
        end
        4'hc: begin
          alu_res = {status_r[ST_C], opnd[7:1]};
          alu_c   = opnd[0];
        end
        4'hd: begin
          alu_res = {opnd[6:0], status_r[ST_C]};
          alu_c   = opnd[7];
        end
        4'he:    alu_res = {opnd[3:0], opnd[7:4]};
        4'hf: begin
          alu_res  = opnd + 8'h01;
          alu_skip = (opnd == 8'hff);
        end
        default: alu_res = opnd;
      endcase
    end
  end

  // commit decisions, all taken at the end of phase four
  assign commit   = (ph_r == PH_FOUR);
  assign wr_core  = to_f & ~ext;
  assign pcl_wr   = wr_core & (ea[6:0] == A_PC_LOW);
  assign flow     = is_goto | is_call | is_ret | pcl_wr;
  assign take_irq = irq_req & irq_enable & ~in_isr_r & ~flow & ~skip_r;
  assign push     = commit & (is_call | take_irq);
  assign pop      = commit & is_ret;
  assign pc_inc   = pc_r + 13'h0001;
  assign pc_tgt   = is_ret ? stack_r[3'(sp_r - 3'h1)] :
                    (is_goto | is_call) ?
                      {pc_high_r[4:3], instruction_latch_r[10:0]} :
                    pcl_wr ? {pc_high_r, res_r} : IRQ_VEC;
  // target minus one so the phase-one increment lands on it
  assign pc_nxt   = (ph_r == PH_ONE) ? pc_inc :
                    (commit & (flow | take_irq)) ? pc_tgt - 13'h0001 : pc_r;

  // status: explicit write first, then alu flags on top
  always_comb begin
    status_base = (wr_core & (ea[6:0] == A_STATUS)) ? res_r : status_r;
    status_nxt  = status_base;
    if (upd_c) status_nxt[ST_C] = alu_c_r;
    if (upd_dc) status_nxt[ST_DC] = alu_dc_r;
    if (upd_z) status_nxt[ST_Z] = (res_r == 8'h00);
  end

  assign co_en = clock_out_select & (external_rc_osc_mode
                                   | internal_rc_osc_mode);

  // phase counter and program fetch side
  always_ff @(posedge clk) begin
    if (core_rst) begin
      ph_r        <= PH_ONE;
      pc_r        <= PC_RST;
      prog_addr_r <= RESET_VEC;
    end else begin
      ph_r <= rcad_phase_e'(ph_r + 2'b01);
      pc_r <= pc_nxt;
      if (ph_r == PH_ONE) prog_addr_r <= pc_inc;
    end
  end

  // prefetched word is dropped on any flow change or skip
  always_ff @(posedge clk) begin
    if (core_rst) instruction_latch_r <= OP_NOP;
    else if (commit) begin
      if (flow | skip_r | take_irq) instruction_latch_r <= OP_NOP;
      else instruction_latch_r <= prog_data;
    end
  end

  // data side: read strobe in phase two, write strobe in phase four
  always_ff @(posedge clk) begin
    if (core_rst) begin
      data_addr_r  <= 8'h00;
      data_rd_r    <= 1'b0;
      data_wr_r    <= 1'b0;
      data_wdata_r <= 8'h00;
    end else begin
      if (ph_r == PH_ONE) data_addr_r <= ea;
      data_rd_r    <= (ph_r == PH_ONE) & rd_f & ext;
      data_wr_r    <= (ph_r == PH_THREE) & to_f & ext;
      if (ph_r == PH_THREE) data_wdata_r <= alu_res;
    end
  end

  // alu result captured once the operand has arrived
  always_ff @(posedge clk) begin
    if (core_rst) begin
      res_r    <= 8'h00;
      alu_c_r  <= 1'b0;
      alu_dc_r <= 1'b0;
      skip_r   <= 1'b0;
    end else if (ph_r == PH_THREE) begin
      res_r    <= alu_res;
      alu_c_r  <= alu_c;
      alu_dc_r <= alu_dc;
      skip_r   <= alu_skip;
    end
  end

  // accumulator and core registers update at the end of phase four
  always_ff @(posedge clk) begin
    if (core_rst) begin
      w_r       <= W_RST;
      status_r  <= STATUS_RST;
      pointer_r <= POINTER_RST;
      pc_high_r <= PCHI_RST;
    end else if (commit) begin
      if (to_w) w_r <= res_r;
      status_r <= status_nxt;
      if (wr_core & (ea[6:0] == A_POINTER)) pointer_r <= res_r;
      if (wr_core & (ea[6:0] == A_PC_HIGH)) pc_high_r <= res_r[4:0];
    end
  end

  // return stack; wraps silently on overflow like a ring
  always_ff @(posedge clk) begin
    if (core_rst) begin
      sp_r     <= 3'h0;
      in_isr_r <= 1'b0;
    end else if (commit) begin
      if (push) sp_r <= 3'(sp_r + 3'h1);
      else if (pop) sp_r <= 3'(sp_r - 3'h1);
      if (take_irq) in_isr_r <= 1'b1;
      else if (instruction_latch_r == OP_RETFIE) in_isr_r <= 1'b0;
    end
  end

  // stack words need no reset, only the pointer is control state
  always_ff @(posedge clk) begin
    if (push) stack_r[sp_r] <= pc_r;
  end

  // cycle-rate clock: low in phases one and two, high in three and four
  always_ff @(posedge clk) begin
    if (core_rst) clk_out_r <= 1'b0;
    else clk_out_r <= co_en & ((ph_r == PH_TWO) | (ph_r == PH_THREE));
  end

  assign prog_addr              = prog_addr_r;
  assign data_addr              = data_addr_r;
  assign data_rd                = data_rd_r;
  assign data_wr                = data_wr_r;
  assign data_wdata             = data_wdata_r;
  assign cycle_rate_clock_out   = clk_out_r;
  assign master_clear_pullup_on = pullup_r;

  // marks the first fetch after reset, for checking only
  always_ff @(posedge clk) begin
    if (core_rst) fresh_r <= 1'b1;
    else if (ph_r == PH_ONE) fresh_r <= 1'b0;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (core_rst);

  sequence s_phase_walk;
    ph_r == PH_TWO ##1 ph_r == PH_THREE ##1 ph_r == PH_FOUR ##1 ph_r == PH_ONE;
  endsequence

  sequence s_flush_then_target;
    instruction_latch_r == OP_NOP ##3 prog_addr_r == $past(pc_tgt, 4);
  endsequence

  a_phase_order: assert property (
    ph_r == PH_ONE |=> s_phase_walk)
    else $error("phase sequence broken");

  a_fetch_phase: assert property (
    $changed(prog_addr_r) |-> $past(ph_r) == PH_ONE)
    else $error("fetch address moved outside phase one");

  a_reset_fetch: assert property (
    fresh_r && ph_r == PH_ONE |=> prog_addr_r == RESET_VEC)
    else $error("first fetch not at reset vector");

  a_read_phase: assert property (
    data_rd_r |-> ph_r == PH_TWO && !data_wr_r)
    else $error("data read outside phase two");

  a_write_phase: assert property (
    data_wr_r |-> ph_r == PH_FOUR && data_addr_r == $past(data_addr_r, 2))
    else $error("data write outside phase four");

  a_latch_phase: assert property (
    $changed(instruction_latch_r) |-> $past(ph_r) == PH_FOUR)
    else $error("instruction latched outside phase four");

  a_branch_flush: assert property (
    commit && (is_goto || is_call) |=> s_flush_then_target)
    else $error("branch did not flush and refetch");

  a_irq_vector: assert property (
    commit && take_irq |=> ##1 prog_addr_r == IRQ_VEC)
    else $error("interrupt did not vector");

  a_add_carry: assert property (
    ph_r == PH_THREE && is_byte && op == 4'h7 |=>
      {alu_c_r, res_r} == {1'b0, $past(b_op)} + {1'b0, $past(w_r)})
    else $error("add result or carry wrong");

  a_sub_borrow: assert property (
    ph_r == PH_THREE && is_sub |=> alu_c_r == ($past(b_op) >= $past(w_r)))
    else $error("subtract carry is not no-borrow");

  a_zero_flag: assert property (
    commit && upd_z |=> status_r[ST_Z] == ($past(res_r) == 8'h00))
    else $error("zero flag wrong");

  a_clock_out: assert property (
    ph_r == PH_TWO && co_en |=> clk_out_r)
    else $error("cycle clock not high in phase three");

endmodule // rcad_core

/* hw/rcad_pkg.sv */
// constants, phase type and core register map for the risc core datapath
// assumes a single 125 MHz clock that stands in for the oscillator input
package rcad_pkg;

  // clock and cycle structure
  localparam int CLK_PERIOD_NS = 8;
  localparam int PHASES_PER_CY = 4;
  localparam int CY_PERIOD_NS  = CLK_PERIOD_NS * PHASES_PER_CY;

  // widths
  localparam int INSN_W  = 14;
  localparam int PC_W    = 13;
  localparam int DATA_W  = 8;
  localparam int DADDR_W = 8;
  localparam int STACK_N = 8;
  localparam int SP_W    = 3;

  // program counter values
  localparam logic [12:0] RESET_VEC = 13'h0000;
  localparam logic [12:0] IRQ_VEC   = 13'h0004;
  localparam logic [12:0] PC_RST    = 13'h1fff; // first increment hits 0

  // special opcodes
  localparam logic [13:0] OP_NOP    = 14'h0000;
  localparam logic [13:0] OP_RETURN = 14'h0008;
  localparam logic [13:0] OP_RETFIE = 14'h0009;

  // core registers, decoded on the low seven address bits in both banks
  localparam logic [6:0] A_INDIRECT = 7'h00;
  localparam logic [6:0] A_PC_LOW   = 7'h02;
  localparam logic [6:0] A_STATUS   = 7'h03;
  localparam logic [6:0] A_POINTER  = 7'h04;
  localparam logic [6:0] A_PC_HIGH  = 7'h0a;

  // status fields
  localparam int ST_C   = 0;
  localparam int ST_DC  = 1;
  localparam int ST_Z   = 2;
  localparam int ST_RP0 = 5;

  // reset values
  localparam logic [7:0] STATUS_RST  = 8'h18;
  localparam logic [7:0] POINTER_RST = 8'h00;
  localparam logic [7:0] W_RST       = 8'h00;
  localparam logic [4:0] PCHI_RST    = 5'h00;

  // byte-oriented ops that update only the zero flag, indexed by op field
  localparam logic [15:0] Z_BYTE_MASK = 16'h077a;

  // the four phases of one instruction cycle
  typedef enum logic [1:0] {
    PH_ONE   = 2'b00,
    PH_TWO   = 2'b01,
    PH_THREE = 2'b10,
    PH_FOUR  = 2'b11
  } rcad_phase_e;

endpackage

/* tb/rcad_mem_model.sv */
// program and data memory model facing the risc core datapath
// assumes the core's synchronous bus timing on one shared clock
`timescale 1ns/1ps
module rcad_mem_model
  import rcad_pkg::*;
(
  input  logic        clk,
  input  logic [12:0] prog_addr,
  input  logic        data_rd,
  input  logic        data_wr,
  input  logic [7:0]  data_addr,
  input  logic [7:0]  data_wdata,
  output logic [13:0] prog_data,
  output logic [7:0]  data_rdata
);
  logic [13:0] pmem [0:8191];
  logic [7:0]  dmem [0:255];

  // known values before the first edge
  initial begin
    prog_data  = 14'h0000;
    data_rdata = 8'h00;
  end

  // whole word each clock from an array of its own
  always @(posedge clk) begin
    prog_data <= pmem[prog_addr];
  end

  // read data holds one clock only, then toggles so stale use shows
  always @(posedge clk) begin
    if (data_rd) begin
      data_rdata <= dmem[data_addr];
    end else begin
      data_rdata <= ~data_rdata;
    end
    if (data_wr) begin
      dmem[data_addr] <= data_wdata;
    end
  end
endmodule // rcad_mem_model

/* tb/tb_rcad_core.sv */
// self-checking bench for the risc core datapath, one task per scenario
// assumes the memory model sits on both buses; inputs move at negedge
`timescale 1ns/1ps
module tb_rcad_core import rcad_pkg::*;;
  localparam logic [13:0] OP_LDL  = 14'h3000;
  localparam logic [13:0] OP_ADDL = 14'h3e00;
  localparam logic [13:0] OP_SUBL = 14'h3c00;
  localparam logic [13:0] OP_ANDL = 14'h3900;
  localparam logic [13:0] OP_XORL = 14'h3a00;
  localparam logic [13:0] OP_ORL  = 14'h3800;
  localparam logic [13:0] OP_STW  = 14'h0080;
  localparam logic [13:0] OP_LDW  = 14'h0800;
  localparam logic [13:0] OP_ROTL = 14'h0d80;
  localparam logic [13:0] OP_ADDF = 14'h0700;
  localparam logic [13:0] OP_JMP  = 14'h2800;

  logic        clk;
  logic        reset;
  logic        master_clear_in;
  logic        master_clear_enable;
  logic        external_rc_osc_mode;
  logic        internal_rc_osc_mode;
  logic        clock_out_select;
  logic        irq_req;
  logic        irq_enable;
  logic [13:0] prog_data;
  logic [7:0]  data_rdata;
  logic [12:0] prog_addr;
  logic [7:0]  data_addr;
  logic        data_rd;
  logic        data_wr;
  logic [7:0]  data_wdata;
  logic        cycle_rate_clock_out;
  logic        master_clear_pullup_on;
  int          errors;
  int          samples_checked;
  int          ld_pc;
  int          n_run;
  logic [12:0] pa_q [$];

  rcad_core rcad_core_inst (
    .clk                    (clk),
    .reset                  (reset),
    .master_clear_in        (master_clear_in),
    .master_clear_enable    (master_clear_enable),
    .external_rc_osc_mode   (external_rc_osc_mode),
    .internal_rc_osc_mode   (internal_rc_osc_mode),
    .clock_out_select       (clock_out_select),
    .irq_req                (irq_req),
    .irq_enable             (irq_enable),
    .prog_data              (prog_data),
    .data_rdata             (data_rdata),
    .prog_addr              (prog_addr),
    .data_addr              (data_addr),
    .data_rd                (data_rd),
    .data_wr                (data_wr),
    .data_wdata             (data_wdata),
    .cycle_rate_clock_out   (cycle_rate_clock_out),
    .master_clear_pullup_on (master_clear_pullup_on)
  );

  rcad_mem_model rcad_mem_model_inst (
    .clk        (clk),
    .prog_addr  (prog_addr),
    .data_rd    (data_rd),
    .data_wr    (data_wr),
    .data_addr  (data_addr),
    .data_wdata (data_wdata),
    .prog_data  (prog_data),
    .data_rdata (data_rdata)
  );

  // 125 mhz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // fetch address history, restarted by every reset
  always @(negedge clk) begin
    if (reset) begin
      pa_q.delete();
    end else if (pa_q.size() == 0 || pa_q[$] !== prog_addr) begin
      pa_q.push_back(prog_addr);
    end
  end

  // four-state compare so an unknown never passes
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] fm(input int a);
    return rcad_mem_model_inst.dmem[a];
  endfunction

  // refill memories while the core is held, so no stray write lands
  task automatic load_start();
    @(negedge clk);
    reset = 1'b1;
    ld_pc = 0;
    for (int i = 0; i < 8192; i++) begin
      rcad_mem_model_inst.pmem[i] = OP_NOP;
    end
    for (int i = 0; i < 256; i++) begin
      rcad_mem_model_inst.dmem[i] = 8'h00;
    end
  endtask

  task automatic op(input logic [13:0] w);
    rcad_mem_model_inst.pmem[ld_pc] = w;
    ld_pc++;
  endtask

  task automatic release_core();
    repeat (3) @(negedge clk);
    reset = 1'b0;
  endtask

  // n counts negedges from release; end marker is a store to 7fh
  // word k executes one cycle after its fetch: strobe seen at 7 + 4k
  task automatic run_to_mark(output int n);
    n = 0;
    while (!(data_wr === 1'b1 && data_addr === 8'h7f) && n < 600) begin
      @(negedge clk);
      n++;
    end
    if (n >= 600) begin
      check("end marker", 16'h0, 16'h1);
      conclude();
    end
    @(negedge clk);
  endtask

  // phase pattern of the cycle clock and first fetches
  task automatic s_fetch_clock();
    load_start();
    internal_rc_osc_mode = 1'b1;
    clock_out_select = 1'b1;
    release_core();
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      check("clock out", cycle_rate_clock_out,
            (i < 12) && (i % 4 == 1 || i % 4 == 2));
      if (i == 3) check("first fetch", prog_addr, RESET_VEC);
      if (i == 4) check("second fetch", prog_addr, 16'h1);
      if (i == 7) begin
        internal_rc_osc_mode = 1'b0;
        external_rc_osc_mode = 1'b1;
      end
      if (i == 11) clock_out_select = 1'b0;
    end
    external_rc_osc_mode = 1'b0;
  endtask

  // arithmetic, logic and shift results with flags read back
  task automatic s_alu();
    logic [7:0] exp_v [7] = '{8'h08, 8'hfd, 8'h18, 8'h1a, 8'h9f, 8'h6e,
                              8'h1f};
    load_start();
    op(OP_LDL | 14'h05);
    op(OP_ADDL | 14'h03);
    op(OP_STW | 14'h20);
    op(OP_SUBL | 14'h05);
    op(OP_STW | 14'h21);
    op(OP_LDW | 14'h03);
    op(OP_STW | 14'h22);
    op(OP_LDL | 14'h0f);
    op(OP_ADDL | 14'h01);
    op(OP_LDW | 14'h03);
    op(OP_STW | 14'h23);
    op(OP_LDL | 14'h08);
    op(OP_SUBL | 14'h08);
    op(OP_LDW | 14'h03);
    op(OP_STW | 14'h26);
    op(OP_LDL | 14'hf0);
    op(OP_ANDL | 14'h3c);
    op(OP_XORL | 14'hff);
    op(OP_ORL | 14'h01);
    op(OP_STW | 14'h24);
    op(OP_ROTL | 14'h24);
    op(OP_ADDF | 14'h24);
    op(OP_STW | 14'h25);
    op(OP_STW | 14'h7f);
    release_core();
    run_to_mark(n_run);
    check("straight cycles", n_run, 4 * 23 + 7);
    for (int i = 0; i < 7; i++) begin
      check("alu file", fm(32 + i), exp_v[i]);
    end
  endtask

  // a jump costs one dead cycle and drops the prefetched word
  task automatic s_branch();
    logic [12:0] exp_a [5] = '{13'h0, 13'h1, 13'h2, 13'h5, 13'h6};
    load_start();
    op(OP_LDL | 14'h11);
    op(OP_JMP | 14'h05);
    op(OP_LDL | 14'h22);
    op(OP_STW | 14'h2a);
    op(OP_NOP);
    op(OP_STW | 14'h27);
    op(OP_STW | 14'h7f);
    release_core();
    run_to_mark(n_run);
    check("jump cycles", n_run, 23);
    check("jump target", fm(8'h27), 16'h11);
    check("skipped store", fm(8'h2a), 16'h0);
    for (int i = 0; i < 5; i++) begin
      check("fetch order", pa_q[i], exp_a[i]);
    end
  endtask

  // pointer and indirect access; core registers stay off the bus
  task automatic s_indirect();
    load_start();
    rcad_mem_model_inst.dmem[4] = 8'hee;
    op(OP_LDL | 14'h21);
    op(OP_STW | 14'h04);
    op(OP_LDL | 14'h5a);
    op(OP_STW | 14'h00);
    op(OP_LDW | 14'h04);
    op(OP_STW | 14'h2b);
    op(OP_LDW | 14'h00);
    op(OP_STW | 14'h2c);
    op(OP_STW | 14'h7f);
    release_core();
    run_to_mark(n_run);
    check("indirect store", fm(8'h21), 16'h5a);
    check("pointer read", fm(8'h2b), 16'h21);
    check("indirect load", fm(8'h2c), 16'h5a);
    check("core reg private", fm(8'h04), 16'hee);
  endtask

  // masked request ignored, then taken through the vector
  task automatic s_irq();
    load_start();
    op(OP_JMP | 14'h10);
    ld_pc = 4;
    op(OP_LDL | 14'h44);
    op(OP_STW | 14'h28);
    op(OP_STW | 14'h7f);
    ld_pc = 16;
    op(OP_NOP);
    op(OP_JMP | 14'h10);
    irq_req = 1'b1;
    release_core();
    repeat (200) @(negedge clk);
    check("masked request", fm(8'h28), 16'h0);
    irq_enable = 1'b1;
    run_to_mark(n_run);
    check("vector entry", fm(8'h28), 16'h44);
    irq_req = 1'b0;
    irq_enable = 1'b0;
  endtask

  // pin reset only when the pin is configured as master clear
  task automatic s_master_clear();
    load_start();
    master_clear_enable = 1'b1;
    release_core();
    repeat (40) @(negedge clk);
    check("pull-up on", master_clear_pullup_on, 16'h1);
    check("running", prog_addr != 13'h0, 16'h1);
    master_clear_in = 1'b0;
    repeat (5) @(negedge clk);
    check("pin clear", prog_addr, RESET_VEC);
    master_clear_in = 1'b1;
    master_clear_enable = 1'b0;
    repeat (40) @(negedge clk);
    master_clear_in = 1'b0;
    repeat (8) @(negedge clk);
    check("pin ignored", prog_addr != 13'h0, 16'h1);
    check("pull-up off", master_clear_pullup_on, 16'h0);
    master_clear_in = 1'b1;
  endtask

  // main sequence
  initial begin
    errors = 0;
    samples_checked = 0;
    reset = 1'b1;
    master_clear_in = 1'b1;
    master_clear_enable = 1'b0;
    external_rc_osc_mode = 1'b0;
    internal_rc_osc_mode = 1'b0;
    clock_out_select = 1'b0;
    irq_req = 1'b0;
    irq_enable = 1'b0;
    s_fetch_clock();
    s_alu();
    s_branch();
    s_indirect();
    s_irq();
    s_master_clear();
    conclude();
  end
endmodule // tb_rcad_core
